// ### shared/ecs_clock_regs.vh
// Operation
// - clock source selection is read/write and reads back the selected mode
// - code 8 takes the sample clock straight from the external input, no PLL
// - code 32 runs the internal PLL with the external input as reference
// - in external reference mode the PLL reference comes from the connector
// - termination control 1 switches on 50 Ohm termination, 0 leaves it open
// - termination applies only while the connector is an input
// - threshold in mV is read/write, signed, -5000 through +5000
// - lower limit, upper limit and step of the threshold read back in mV
// - a threshold of 0 mV is accepted for AC-coupled clocks
// - PLL settings come from reference and requested rate; some rates unreachable
// - requested sample rate is written; read returns nearest achievable rate
`ifndef ECS_CLOCK_REGS_VH
`define ECS_CLOCK_REGS_VH

// parameter indices, used directly as the access address
`define ECS_ADDR_SAMPLE_RATE 16'h4e20
`define ECS_ADDR_TERM_ENABLE 16'h4e98
`define ECS_ADDR_REF_FREQ 16'h4eac
`define ECS_ADDR_CLOCK_SRC 16'h4ee8
`define ECS_ADDR_THRESHOLD 16'ha5aa
`define ECS_ADDR_THR_MIN 16'ha5b7
`define ECS_ADDR_THR_MAX 16'ha5b8
`define ECS_ADDR_THR_STEP 16'ha5b9

// clock source codes
`define ECS_MODE_INT_PLL 32'h0000_0001
`define ECS_MODE_DIRECT_EXT 32'h0000_0008
`define ECS_MODE_EXT_REF_PLL 32'h0000_0020

// reset values
`define ECS_RST_CLOCK_SRC 32'h0000_0001
`define ECS_RST_TERM 1'b0
`define ECS_RST_THRESHOLD 32'h0000_0000
`define ECS_RST_REF_FREQ 32'h0000_0000
`define ECS_RST_SAMPLE_RATE 32'h0000_0000

// threshold limits in mV
`define ECS_THR_MIN_MV (-5000)
`define ECS_THR_MAX_MV 5000
`define ECS_THR_STEP_MV 1

// PLL multiplier width and divider step count
`define ECS_PLL_MULT_W 8
`define ECS_DIV_STEPS 6'h20

`endif

// ### rtl/ecs_pll_calc.v
`timescale 1ns/10ps
`default_nettype none
`include "ecs_clock_regs.vh"

module ecs_pll_calc #(
  parameter MULT_W = `ECS_PLL_MULT_W
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_reset,
  // request
  input wire i_start,
  input wire [31:0] i_req_hz,
  input wire [31:0] i_ref_hz,
  // result
  output reg o_busy,
  output reg o_done,
  output reg [MULT_W-1:0] o_mult,
  output reg [31:0] o_rate_hz,
  output reg o_clamped
);

  localparam ST_IDLE = 2'd0;
  localparam ST_DIV = 2'd1;
  localparam ST_FIN = 2'd2;
  localparam [32:0] MULT_MAX = {{(33-MULT_W){1'b0}}, {MULT_W{1'b1}}};

  reg [1:0] state;
  reg [32:0] rem;
  reg [31:0] quo;
  reg [31:0] den;
  reg [5:0] cnt;

  wire [32:0] shifted = {rem[31:0], quo[31]};
  wire ge = shifted >= {1'b0, den};
  // round to nearest multiple of the reference
  wire round_up = {rem, 1'b0} >= {2'b00, den};
  wire [32:0] q_round = {1'b0, quo} + {32'h0000_0000, round_up};
  wire too_low = (q_round == 33'h0_0000_0000);
  wire too_high = q_round > MULT_MAX;
  wire [MULT_W-1:0] mult_c = too_low ? {{(MULT_W-1){1'b0}}, 1'b1} :
                             too_high ? {MULT_W{1'b1}} : q_round[MULT_W-1:0];
  wire [MULT_W+31:0] prod = {{32{1'b0}}, mult_c} * {{MULT_W{1'b0}}, den};
  // the register is 32 bits wide, so higher products saturate
  wire prod_ovf = |prod[MULT_W+31:32];

  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state <= ST_IDLE;
      rem <= 33'h0_0000_0000;
      quo <= 32'h0000_0000;
      den <= 32'h0000_0000;
      cnt <= 6'h00;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_mult <= {{(MULT_W-1){1'b0}}, 1'b1};
      o_rate_hz <= 32'h0000_0000;
      o_clamped <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            rem <= 33'h0_0000_0000;
            quo <= i_req_hz;
            den <= i_ref_hz;
            cnt <= 6'h00;
            o_busy <= 1'b1;
            state <= ST_DIV;
          end
        end
        ST_DIV: begin
          rem <= ge ? shifted - {1'b0, den} : shifted;
          quo <= {quo[30:0], ge};
          cnt <= cnt + 6'h01;
          if (cnt == `ECS_DIV_STEPS - 6'h01) begin
            state <= ST_FIN;
          end
        end
        ST_FIN: begin
          if (den == 32'h0000_0000) begin
            // no reference known: nothing reachable
            o_rate_hz <= 32'h0000_0000;
            o_clamped <= 1'b1;
          end else begin
            o_mult <= mult_c;
            o_rate_hz <= prod_ovf ? 32'hffff_ffff : prod[31:0];
            o_clamped <= too_low | too_high | prod_ovf;
          end
          o_busy <= 1'b0;
          o_done <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
          o_busy <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### rtl/ecs_clock_src_cfg.v
`timescale 1ns/10ps
`default_nettype none
`include "ecs_clock_regs.vh"

module ecs_clock_src_cfg #(
  parameter integer THR_MIN_MV = `ECS_THR_MIN_MV,
  parameter integer THR_MAX_MV = `ECS_THR_MAX_MV,
  parameter integer THR_STEP_MV = `ECS_THR_STEP_MV,
  parameter MULT_W = `ECS_PLL_MULT_W
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_reset,
  // parameter access port
  input wire i_param_wr,
  input wire i_param_rd,
  input wire [15:0] i_param_addr,
  input wire [31:0] i_param_wdata,
  output reg [31:0] o_param_rdata,
  output reg o_param_ack,
  // clock path control
  output reg o_clk_direct_ext,
  output reg o_pll_enable,
  output reg o_pll_ref_ext,
  output reg o_term_on,
  output reg [31:0] o_threshold_mv,
  // PLL settings
  output reg [MULT_W-1:0] o_pll_mult,
  output reg o_pll_load,
  output reg o_pll_busy,
  output reg o_rate_unreachable
);

  localparam signed [31:0] MIN_S = THR_MIN_MV;
  localparam signed [31:0] MAX_S = THR_MAX_MV;
  localparam signed [31:0] STEP_S = THR_STEP_MV;

  reg [31:0] clock_src_select;
  reg input_termination_enable;
  reg signed [31:0] input_threshold_mv;
  reg [31:0] reference_frequency_hz;
  reg [31:0] requested_sample_rate_hz;
  reg calc_start;

  wire wr_src = i_param_wr && (i_param_addr == `ECS_ADDR_CLOCK_SRC);
  wire wr_term = i_param_wr && (i_param_addr == `ECS_ADDR_TERM_ENABLE);
  wire wr_thr = i_param_wr && (i_param_addr == `ECS_ADDR_THRESHOLD);
  wire wr_ref = i_param_wr && (i_param_addr == `ECS_ADDR_REF_FREQ);
  wire wr_rate = i_param_wr && (i_param_addr == `ECS_ADDR_SAMPLE_RATE);

  // unknown codes are dropped so the clock path never sees an illegal mode
  wire src_code_ok = (i_param_wdata == `ECS_MODE_INT_PLL) ||
                     (i_param_wdata == `ECS_MODE_DIRECT_EXT) ||
                     (i_param_wdata == `ECS_MODE_EXT_REF_PLL);

  wire mode_direct = (clock_src_select == `ECS_MODE_DIRECT_EXT);
  wire mode_ext_ref = (clock_src_select == `ECS_MODE_EXT_REF_PLL);
  wire mode_int = (clock_src_select == `ECS_MODE_INT_PLL);

  wire calc_busy;
  wire calc_done;
  wire [MULT_W-1:0] calc_mult;
  wire [31:0] calc_rate;
  wire calc_clamped;

  // threshold clamp and grid rounding
  reg signed [31:0] thr_clamped;
  reg signed [31:0] thr_off;
  reg signed [31:0] thr_q;
  reg signed [31:0] next_threshold;
  always @* begin
    thr_clamped = $signed(i_param_wdata);
    thr_off = 32'sh0000_0000;
    thr_q = 32'sh0000_0000;
    next_threshold = 32'sh0000_0000;
    if ($signed(i_param_wdata) < MIN_S) begin
      thr_clamped = MIN_S;
    end else if ($signed(i_param_wdata) > MAX_S) begin
      thr_clamped = MAX_S;
    end
    thr_off = thr_clamped - MIN_S;
    thr_q = (thr_off + (STEP_S >>> 1)) / STEP_S;
    next_threshold = MIN_S + thr_q * STEP_S;
    if (next_threshold > MAX_S) begin
      next_threshold = next_threshold - STEP_S;
    end
  end

  // register writes
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      clock_src_select <= `ECS_RST_CLOCK_SRC;
      input_termination_enable <= `ECS_RST_TERM;
      input_threshold_mv <= `ECS_RST_THRESHOLD;
      reference_frequency_hz <= `ECS_RST_REF_FREQ;
      requested_sample_rate_hz <= `ECS_RST_SAMPLE_RATE;
      calc_start <= 1'b0;
    end else begin
      calc_start <= 1'b0;
      if (wr_src && src_code_ok) begin
        clock_src_select <= i_param_wdata;
      end
      if (wr_term) begin
        input_termination_enable <= i_param_wdata[0];
      end
      if (wr_thr) begin
        // 0 mV lies on the grid and is kept as written
        input_threshold_mv <= next_threshold;
      end
      if (wr_ref) begin
        // taken as given; the host owns its accuracy
        reference_frequency_hz <= i_param_wdata;
      end
      if (wr_rate) begin
        // uses the reference already held, so it must be written first
        requested_sample_rate_hz <= i_param_wdata;
        calc_start <= 1'b1;
      end
    end
  end

  // a rate written while a calculation runs is held and started afterwards
  reg calc_pending;
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      calc_pending <= 1'b0;
    end else if (calc_start) begin
      calc_pending <= 1'b1;
    end else if (!calc_busy) begin
      calc_pending <= 1'b0;
    end
  end

  ecs_pll_calc #(
    .MULT_W(MULT_W)
  ) u_calc (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_start(calc_pending && !calc_busy),
    .i_req_hz(requested_sample_rate_hz),
    .i_ref_hz(reference_frequency_hz),
    .o_busy(calc_busy),
    .o_done(calc_done),
    .o_mult(calc_mult),
    .o_rate_hz(calc_rate),
    .o_clamped(calc_clamped)
  );

  // read mux
  reg [31:0] next_rdata;
  always @* begin
    case (i_param_addr)
      `ECS_ADDR_CLOCK_SRC: next_rdata = clock_src_select;
      `ECS_ADDR_TERM_ENABLE: next_rdata = {31'h0000_0000, input_termination_enable};
      `ECS_ADDR_THRESHOLD: next_rdata = input_threshold_mv;
      `ECS_ADDR_THR_MIN: next_rdata = MIN_S;
      `ECS_ADDR_THR_MAX: next_rdata = MAX_S;
      `ECS_ADDR_THR_STEP: next_rdata = STEP_S;
      `ECS_ADDR_REF_FREQ: next_rdata = reference_frequency_hz;
      `ECS_ADDR_SAMPLE_RATE: next_rdata = calc_rate;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // answers and control outputs
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_param_rdata <= 32'h0000_0000;
      o_param_ack <= 1'b0;
      o_clk_direct_ext <= 1'b0;
      o_pll_enable <= 1'b1;
      o_pll_ref_ext <= 1'b0;
      o_term_on <= 1'b0;
      o_threshold_mv <= 32'h0000_0000;
      o_pll_mult <= {{(MULT_W-1){1'b0}}, 1'b1};
      o_pll_load <= 1'b0;
      o_pll_busy <= 1'b0;
      o_rate_unreachable <= 1'b0;
    end else begin
      o_param_ack <= i_param_wr | i_param_rd;
      if (i_param_rd) begin
        o_param_rdata <= next_rdata;
      end
      o_clk_direct_ext <= mode_direct;
      o_pll_enable <= mode_int | mode_ext_ref;
      o_pll_ref_ext <= mode_ext_ref;
      o_term_on <= input_termination_enable & (mode_direct | mode_ext_ref);
      o_threshold_mv <= input_threshold_mv;
      o_pll_busy <= calc_busy | calc_pending;
      o_pll_load <= calc_done & ~calc_clamped;
      if (calc_done) begin
        o_pll_mult <= calc_mult;
        o_rate_unreachable <= calc_clamped;
      end
    end
  end

endmodule
`default_nettype wire

// ### verification/ecs_cfg_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "ecs_clock_regs.vh"
module ecs_cfg_sva #(
  parameter integer THR_MIN_MV = -5000,
  parameter integer THR_MAX_MV = 5000
) (
  // watched ports
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_param_wr,
  input wire logic i_param_rd,
  input wire logic [15:0] i_param_addr,
  input wire logic [31:0] i_param_wdata,
  input wire logic o_param_ack,
  input wire logic o_clk_direct_ext,
  input wire logic o_pll_enable,
  input wire logic o_pll_ref_ext,
  input wire logic o_term_on,
  input wire logic [31:0] o_threshold_mv,
  input wire logic o_pll_load,
  input wire logic o_pll_busy
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire logic mode_wr = i_param_wr && i_param_addr == `ECS_ADDR_CLOCK_SRC;
  wire logic rate_wr = i_param_wr && i_param_addr == `ECS_ADDR_SAMPLE_RATE;
  AST_ACK: assert property ((i_param_wr || i_param_rd) |=> o_param_ack)
    else $error("access not acknowledged");
  AST_NO_ACK: assert property (!(i_param_wr || i_param_rd) |=> !o_param_ack)
    else $error("ack without access");
  AST_MODE8: assert property (mode_wr && i_param_wdata == 32'h0000_0008 |-> ##2 o_clk_direct_ext && !o_pll_enable)
    else $error("direct clock path not set");
  AST_MODE32: assert property (mode_wr && i_param_wdata == 32'h0000_0020 |-> ##2 o_pll_ref_ext && o_pll_enable)
    else $error("external reference path not set");
  AST_TERM: assert property (o_term_on |-> o_clk_direct_ext || o_pll_ref_ext)
    else $error("termination while connector unused");
  AST_THR: assert property ($signed(o_threshold_mv) >= THR_MIN_MV && $signed(o_threshold_mv) <= THR_MAX_MV)
    else $error("threshold out of range");
  AST_BUSY: assert property (rate_wr |-> ##[2:5] o_pll_busy)
    else $error("rate write did not start calculation");
  AST_CALC_END: assert property ($rose(o_pll_busy) |-> ##[1:120] !o_pll_busy)
    else $error("calculation never ends");
  AST_LOAD: assert property (o_pll_load |=> !o_pll_load)
    else $error("load longer than one cycle");
  COV_MODE8: cover property (mode_wr && i_param_wdata == 32'h0000_0008);
  COV_LOAD: cover property (o_pll_load);
  COV_TERM: cover property (o_term_on);
endmodule
bind ecs_clock_src_cfg ecs_cfg_sva #(.THR_MIN_MV(THR_MIN_MV), .THR_MAX_MV(THR_MAX_MV)) u_sva (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_param_wr(i_param_wr), .i_param_rd(i_param_rd),
  .i_param_addr(i_param_addr), .i_param_wdata(i_param_wdata), .o_param_ack(o_param_ack),
  .o_clk_direct_ext(o_clk_direct_ext), .o_pll_enable(o_pll_enable), .o_pll_ref_ext(o_pll_ref_ext),
  .o_term_on(o_term_on), .o_threshold_mv(o_threshold_mv), .o_pll_load(o_pll_load), .o_pll_busy(o_pll_busy));
`default_nettype wire

// ### verification/ecs_ext_ref_gen.sv
`timescale 1ns/10ps
`default_nettype none
module ecs_ext_ref_gen #(
  parameter integer FREQ_HZ = 10000000
) (
  // connector use
  input wire logic i_enable,
  // clock at the connector
  output logic o_ref_clk
);
  // stands low while unused, so no stale level passes for a clock
  initial o_ref_clk = 1'b0;
  always begin
    #(500000000.0 / FREQ_HZ);
    o_ref_clk = i_enable ? ~o_ref_clk : 1'b0;
  end
endmodule
`default_nettype wire

// ### verification/external_clock_source_config_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "ecs_clock_regs.vh"
module external_clock_source_config_test;
  localparam int REF_HZ = 10000000;
  logic clk, rst, wr, rd;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  wire logic [31:0] rdata, thr;
  wire logic [7:0] mult;
  wire logic ack, dext, pll_en, rext, term, load, busy, unr, ref_clk;
  int n_fail = 0, n_tests = 0, v, ev;
  int md[4] = '{8, 32, 5, 1};
  int ex[4] = '{8, 32, 32, 1};
  int tv[5] = '{0, -5000, 5000, 6000, -7000};
  logic [31:0] rq[2] = '{32'd31000000, 32'd4000000000};
  logic [31:0] er[2] = '{32'd30000000, 32'd2550000000};
  logic [31:0] em[2] = '{32'd3, 32'd255};

  ecs_clock_src_cfg dut (.i_clk_sys(clk), .i_reset(rst), .i_param_wr(wr), .i_param_rd(rd),
    .i_param_addr(addr), .i_param_wdata(wdata), .o_param_rdata(rdata), .o_param_ack(ack),
    .o_clk_direct_ext(dext), .o_pll_enable(pll_en), .o_pll_ref_ext(rext), .o_term_on(term),
    .o_threshold_mv(thr), .o_pll_mult(mult), .o_pll_load(load), .o_pll_busy(busy),
    .o_rate_unreachable(unr));
  ecs_ext_ref_gen #(.FREQ_HZ(REF_HZ)) u_gen (.i_enable(dext | rext), .o_ref_clk(ref_clk));

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // strobe held across calls; one access per edge
  task acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [31:0] x);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    exp_q.push_back({!w, x});
    @(negedge clk);
  endtask
  task idle;
    wr = 0;
    rd = 0;
    @(negedge clk);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(negedge clk) if (ack === 1'b1) begin
    if (exp_q.size() == 0) check(1, 0);
    else begin
      e = exp_q.pop_front();
      if (e[32]) check(rdata, e[31:0]);
    end
  end
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial begin
    #100000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    rst = 1; wr = 0; rd = 0; addr = 0; wdata = 0;
    v = $urandom(12627);
    repeat (8) @(negedge clk);
    rst = 0;
    acc(0, `ECS_ADDR_CLOCK_SRC, 0, 1);
    acc(1, `ECS_ADDR_THR_MIN, 7, 0);
    acc(0, `ECS_ADDR_THR_MIN, 0, -5000);
    acc(0, `ECS_ADDR_THR_MAX, 0, 5000);
    acc(0, `ECS_ADDR_THR_STEP, 0, 1);
    acc(0, 16'h1234, 0, 0);
    acc(1, `ECS_ADDR_TERM_ENABLE, 1, 0);
    acc(0, `ECS_ADDR_TERM_ENABLE, 0, 1);
    for (int i = 0; i < 4; i++) begin
      acc(1, `ECS_ADDR_CLOCK_SRC, md[i], 0);
      acc(0, `ECS_ADDR_CLOCK_SRC, 0, ex[i]);
      idle;
      check(dext, ex[i] == 8);
      check(rext, ex[i] == 32);
      check(pll_en, ex[i] != 8);
      check(term, ex[i] != 1);
    end
    acc(1, `ECS_ADDR_CLOCK_SRC, 8, 0);
    acc(1, `ECS_ADDR_TERM_ENABLE, 0, 0);
    idle;
    idle;
    check(term, 0);
    for (int i = 0; i < 8; i++) begin
      v = i < 5 ? tv[i] : int'($urandom_range(12000)) - 6000;
      ev = v > 5000 ? 5000 : (v < -5000 ? -5000 : v);
      acc(1, `ECS_ADDR_THRESHOLD, v, 0);
      acc(0, `ECS_ADDR_THRESHOLD, 0, ev);
      idle;
      check(thr, ev);
    end
    acc(1, `ECS_ADDR_CLOCK_SRC, 32, 0);
    acc(1, `ECS_ADDR_REF_FREQ, REF_HZ, 0);
    acc(0, `ECS_ADDR_REF_FREQ, 0, REF_HZ);
    for (int j = 0; j < 2; j++) begin
      acc(1, `ECS_ADDR_SAMPLE_RATE, rq[j], 0);
      idle;
      // clamped results give no load pulse, so wait on busy instead
      for (int k = 0; k < 10 && busy !== 1'b1; k++) @(negedge clk);
      for (int k = 0; k < 100 && busy !== 1'b0; k++) @(negedge clk);
      check(busy, 0);
      check(load, j == 0);
      check(mult, em[j]);
      check(unr, j);
      acc(0, `ECS_ADDR_SAMPLE_RATE, 0, er[j]);
      idle;
    end
    idle;
    tally_and_finish;
  end
endmodule
`default_nettype wire
